/* File: ddrps_capture.sv */
// DDR read strobe delay, local strobe bus, DQ capture and output registers
//
// Behaviour
// - Output registers load with enable, else hold.
// - Output clock enable resets high.
// - Each strobe passes a tuned delay line.
// - Delayed strobes form bus clocking DQ capture.
// - Separate top and bottom reference circuits.
// - One phase shift per side, sides differ.
// - Delay setting settles within 256 cycles.
// - Strobe serves 8, 16 or 32 bits.
// - Phase shift only in banks 3,4,7,8.
// - Side bank ignores strobe, uses reference.
// - Opposite-edge capture, high bit latched.
// - Output enable moves only on falling edge.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`include "ddrps_params.svh"
module ddrps_capture (
   input  wire logic                                   clk_i,
   input  wire logic                                   rst_i,
   input  wire logic                                   wb_cyc_i,
   input  wire logic                                   wb_stb_i,
   input  wire logic                                   wb_we_i,
   input  wire logic [7:0]                             wb_adr_i,
   input  wire logic [3:0]                             wb_sel_i,
   input  wire logic [31:0]                            wb_dat_i,
   output logic      [31:0]                            wb_dat_o,
   output logic                                        wb_ack_o,
   input  wire logic                                   ref_top_clk_i,
   input  wire logic                                   ref_bot_clk_i,
   input  wire logic [`DDRPS_LANES-1:0]                dqs_i,
   input  wire logic [`DDRPS_LANES*`DDRPS_DQ_W-1:0]    dq_i,
   output logic      [`DDRPS_LANES*`DDRPS_DQ_W-1:0]    rd_rise_o,
   output logic      [`DDRPS_LANES*`DDRPS_DQ_W-1:0]    rd_fall_o,
   output logic      [`DDRPS_LANES-1:0]                rd_valid_o,
   input  wire logic [`DDRPS_DQ_W-1:0]                 dout_a_i,
   input  wire logic [`DDRPS_DQ_W-1:0]                 dout_b_i,
   input  wire logic                                   oe_i,
   output logic      [`DDRPS_DQ_W-1:0]                 dq_o,
   output logic                                        dq_oe_o
);
   localparam int NL = `DDRPS_LANES;
   localparam int SL = `DDRPS_SIDE_LANES;
   localparam int DW = `DDRPS_DQ_W;

   logic [31:0]               ctrl_ff, phase_ff, bank_ff, dat_ff;
   logic                      ack_ff;
   logic [NL-1:0]             dqs_s1_ff, dqs_s2_ff;
   logic [NL*DW-1:0]          dq_s1_ff, dq_s2_ff;
   logic [`DDRPS_TAPS-1:0]    line_ff [NL];
   logic [NL-1:0]             dstb_raw, dstb_bus, dstb_d_ff;
   logic [NL*DW-1:0]          hi_ff, rise_ff, fall_ff;
   logic [NL-1:0]             valid_ff;
   logic [DW-1:0]             out_a_ff, out_b_ff, dq_out_ff;
   logic                      oe_ff;
   logic [`DDRPS_TAP_W-1:0]   taps [2];
   logic [1:0]                settled, ref_lvl, ref_rise, ref_fall, cap_ok;
   ddrps_pkg::ddrps_mode_t    mode [2];
   logic [3:0]                bank [2];
   wire                       bus_req, wr_stb, out_ce;
   wire  [31:0]               wmask, rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, unmapped reads give zero
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_stb  = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff; // Lands at the edge ack is seen
   assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign rd_mux  = (wb_adr_i == `DDRPS_ADR_CTRL)  ? ctrl_ff  :
                    (wb_adr_i == `DDRPS_ADR_PHASE) ? phase_ff :
                    (wb_adr_i == `DDRPS_ADR_BANK)  ? bank_ff  :
                    (wb_adr_i == `DDRPS_ADR_STAT)  ? {8'h00, 3'h0, taps[1], 3'h0, taps[0],
                                                      6'h00, settled} :
                                                     32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_req;
         if (bus_req) dat_ff <= rd_mux;
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   // Control registers; byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff  <= `DDRPS_CTRL_RST;
         phase_ff <= `DDRPS_PHASE_RST;
         bank_ff  <= `DDRPS_BANK_RST;
      end else if (wr_stb) begin
         if (wb_adr_i == `DDRPS_ADR_CTRL)  ctrl_ff  <= (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
         if (wb_adr_i == `DDRPS_ADR_PHASE) phase_ff <= (phase_ff & ~wmask) | (wb_dat_i & wmask);
         if (wb_adr_i == `DDRPS_ADR_BANK)  bank_ff  <= (bank_ff & ~wmask) | (wb_dat_i & wmask);
      end
   end

   // Field decode per side; 2'b10 is not a width and falls back to x8
   assign out_ce  = ctrl_ff[`DDRPS_CTRL_CE_BIT];
   assign mode[0] = (ctrl_ff[`DDRPS_CTRL_TMODE] == 2'b10) ? ddrps_pkg::DDRPS_X8 :
                    ddrps_pkg::ddrps_mode_t'(ctrl_ff[`DDRPS_CTRL_TMODE]);
   assign mode[1] = (ctrl_ff[`DDRPS_CTRL_BMODE] == 2'b10) ? ddrps_pkg::DDRPS_X8 :
                    ddrps_pkg::ddrps_mode_t'(ctrl_ff[`DDRPS_CTRL_BMODE]);
   assign bank[0] = bank_ff[`DDRPS_BANK_TOP];
   assign bank[1] = bank_ff[`DDRPS_BANK_BOT];

   ////////////////////////////////////////////////////////////////////////////
   // One reference circuit per side, each with its own phase
   ddrps_phase_ref u_ref_top (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ref_clk_i   (ref_top_clk_i),
      .phase_deg_i (phase_ff[`DDRPS_PHASE_TOP]),
      .taps_o      (taps[0]),
      .settled_o   (settled[0]),
      .ref_lvl_o   (ref_lvl[0]),
      .ref_rise_o  (ref_rise[0]),
      .ref_fall_o  (ref_fall[0])
   );
   ddrps_phase_ref u_ref_bot (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ref_clk_i   (ref_bot_clk_i),
      .phase_deg_i (phase_ff[`DDRPS_PHASE_BOT]),
      .taps_o      (taps[1]),
      .settled_o   (settled[1]),
      .ref_lvl_o   (ref_lvl[1]),
      .ref_rise_o  (ref_rise[1]),
      .ref_fall_o  (ref_fall[1])
   );

   // Only the top and bottom banks own phase-shift hardware
   assign cap_ok[0] = (bank[0] == 4'h3) || (bank[0] == 4'h4);
   assign cap_ok[1] = (bank[1] == 4'h7) || (bank[1] == 4'h8);

   ////////////////////////////////////////////////////////////////////////////
   // Pins are foreign: two flops before any use
   always_ff @(posedge clk_i) begin
      dqs_s1_ff <= dqs_i;
      dqs_s2_ff <= dqs_s1_ff;
      dq_s1_ff  <= dq_i;
      dq_s2_ff  <= dq_s1_ff;
   end

   // Per lane: delay line, strobe bus, DDR capture pair
   for (genvar i = 0; i < NL; i++) begin : g_lane
      localparam int SD  = i / SL;
      localparam int OFS = i % SL;
      localparam int B16 = i - OFS + (OFS & ~1);
      localparam int B32 = i - OFS + (OFS & ~3);
      wire src_x16 = dstb_raw[B16];
      wire src_x32 = dstb_raw[B32];
      wire sel_stb = (mode[SD] == ddrps_pkg::DDRPS_X32) ? src_x32 :
                     (mode[SD] == ddrps_pkg::DDRPS_X16) ? src_x16 : dstb_raw[i];
      wire s_rise  = dstb_bus[i] & ~dstb_d_ff[i];
      wire s_fall  = ~dstb_bus[i] & dstb_d_ff[i];

      // Tap picks the strobe edge into the middle of the data eye
      always_ff @(posedge clk_i) begin
         line_ff[i] <= {line_ff[i][`DDRPS_TAPS-2:0], dqs_s2_ff[i]};
      end
      assign dstb_raw[i] = line_ff[i][taps[SD]];
      // Side banks ignore the read strobe and capture on the reference
      assign dstb_bus[i] = cap_ok[SD] ? sel_stb : ref_lvl[SD];

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            dstb_d_ff[i]      <= 1'b0;
            hi_ff[i*DW+:DW]   <= '0;
            rise_ff[i*DW+:DW] <= '0;
            fall_ff[i*DW+:DW] <= '0;
            valid_ff[i]       <= 1'b0;
         end else begin
            dstb_d_ff[i] <= dstb_bus[i];
            if (s_rise) hi_ff[i*DW+:DW] <= dq_s2_ff[i*DW+:DW];
            if (s_fall) begin
               rise_ff[i*DW+:DW] <= hi_ff[i*DW+:DW];
               fall_ff[i*DW+:DW] <= dq_s2_ff[i*DW+:DW];
            end
            valid_ff[i] <= s_fall & settled[SD];
         end
      end
   end
   assign rd_rise_o  = rise_ff;
   assign rd_fall_o  = fall_ff;
   assign rd_valid_o = valid_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Output registers; enable low freezes them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_a_ff <= '0;
         out_b_ff <= '0;
      end else if (out_ce) begin
         out_a_ff <= dout_a_i;
         out_b_ff <= dout_b_i;
      end
   end

   // Output enable waits for the falling reference edge to meet memory timing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_ff     <= 1'b0;
         dq_out_ff <= '0;
      end else begin
         if (ref_fall[0]) oe_ff <= oe_i;
         dq_out_ff <= ref_lvl[0] ? out_a_ff : out_b_ff;
      end
   end
   assign dq_o    = dq_out_ff;
   assign dq_oe_o = oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_ce_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !out_ce |=> $stable(out_a_ff) && $stable(out_b_ff))
      else $error("output register changed with enable low");
   a_ce_load: assert property (@(posedge clk_i) disable iff (rst_i)
      out_ce |=> out_a_ff == $past(dout_a_i) && out_b_ff == $past(dout_b_i))
      else $error("output register missed a load with enable high");
   a_ce_reset: assert property (@(posedge clk_i)
      rst_i |=> out_ce)
      else $error("output clock enable not high after reset");
   a_delay_tap: assert property (@(posedge clk_i) disable iff (rst_i)
      taps[0] == 5'h00 |-> dstb_raw[0] == $past(dqs_s2_ff[0]))
      else $error("strobe delay line tap zero wrong");
   a_bus_source: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_ok[0] && mode[0] == ddrps_pkg::DDRPS_X8 |-> dstb_bus[1] == dstb_raw[1])
      else $error("strobe bus not fed from its delayed strobe");
   a_x32_share: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_ok[1] && mode[1] == ddrps_pkg::DDRPS_X32 |-> dstb_bus[13] == dstb_raw[10])
      else $error("x32 group not clocked by its leading strobe");
   a_side_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
      !cap_ok[0] |-> dstb_bus[0] == ref_lvl[0])
      else $error("strobe used on a bank without phase shift");
   a_pair_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_valid_o[0] |-> $past(dstb_d_ff[0]) && !$past(dstb_bus[0])
                        && rd_rise_o[7:0] == $past(hi_ff[7:0]))
      else $error("capture pair not presented on strobe fall");
   a_valid_settled: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_valid_o[10] |-> $past(settled[1]))
      else $error("read capture valid before settle");
   a_oe_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      !ref_fall[0] |=> $stable(oe_ff))
      else $error("output enable moved off the falling edge");
   a_same_taps: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_ok[0] && mode[0] == ddrps_pkg::DDRPS_X8 |-> dstb_bus[9] == line_ff[9][taps[0]])
      else $error("lane did not use its side delay setting");
   a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge longer than one cycle");

   c_capture: cover property (@(posedge clk_i) disable iff (rst_i) rd_valid_o[0]);
   c_x16_bot: cover property (@(posedge clk_i) disable iff (rst_i)
      mode[1] == ddrps_pkg::DDRPS_X16 && rd_valid_o[11]);
   c_oe_on:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(dq_oe_o));
   c_fallback: cover property (@(posedge clk_i) disable iff (rst_i) !cap_ok[0] && rd_valid_o[0]);
endmodule : ddrps_capture

/* File: ddrps_capture_bench.sv */
// Self-checking bench for the DDR read strobe capture block
`include "ddrps_params.svh"
module ddrps_capture_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [9:0]  MSK [3] = '{10'h3FF, 10'h155, 10'h111};
   localparam ddrps_pkg::ddrps_mode_t MD [3] = '{ddrps_pkg::DDRPS_X8, ddrps_pkg::DDRPS_X16,
                                                ddrps_pkg::DDRPS_X32};
   localparam logic [31:0] RV [4] = '{`DDRPS_CTRL_RST, `DDRPS_PHASE_RST, `DDRPS_BANK_RST,
                                      32'h0000_0000};
   logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0]   adr = 8'h00, dout_a = 8'h00, dout_b = 8'h00, dq_out;
   logic [31:0]  wdat = 32'h0000_0000, rdat;
   logic         ref_top = 1'b0, ref_bot = 1'b0, oe = 1'b0, dq_oe, send = 1'b0;
   logic         free_bot = 1'b0;
   logic [19:0]  dqs, vld, dqs_en = 20'h0_0000;
   logic [159:0] dq, rise, fall, beat_a = '0, beat_b = '0;
   logic [63:0]  e;
   logic [63:0]  rq [$];
   logic [159:0] tq [$];
   logic [159:0] bq [$];
   int           fcnt = 0, num_errors = 0, cmp_count = 0, cyc_n = 0;
   ////////////////////////////////////////////////////////////
   // System clock and two free-running references, unrelated in phase
   always #2.5 clk_i = ~clk_i;
   initial begin
      #13.3;
      forever #40 ref_top = ~ref_top;
   end
   initial begin
      #31.1;
      forever #40 ref_bot = ~ref_bot;
   end
   // Watchdog sized well past the whole sequence
   initial begin
      #300000;
      num_errors++;
      give_verdict();
   end
   ddrps_capture dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ref_top_clk_i(ref_top), .ref_bot_clk_i(ref_bot), .dqs_i(dqs), .dq_i(dq),
      .rd_rise_o(rise), .rd_fall_o(fall), .rd_valid_o(vld), .dout_a_i(dout_a),
      .dout_b_i(dout_b), .oe_i(oe), .dq_o(dq_out), .dq_oe_o(dq_oe)
   );
   ddrps_ddr_model mem_u (
      .ref_clk_i(ref_top), .send_i(send), .dqs_en_i(dqs_en), .beat_a_i(beat_a),
      .beat_b_i(beat_b), .dqs_o(dqs), .dq_o(dq)
   );
   ////////////////////////////////////////////////////////////
   task automatic cmp(input logic [159:0] got, input logic [159:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // A side presents all ten lanes together or none
   task automatic grp(input logic [9:0] v, input logic [159:0] got, ref logic [159:0] q[$]);
      if (v !== 10'h000) begin
         if (v !== 10'h3FF || q.size() == 0) cmp({150'h0, v}, 160'h0);
         else cmp(got, q.pop_front());
      end
   endtask : grp
   // Monitor: pops the oldest note whenever a full ten-lane result or a read ack shows; bottom results while free_bot are only counted
   always @(posedge clk_i) begin
      cyc_n++;
      grp(vld[9:0], {rise[79:0], fall[79:0]}, tq);
      if (free_bot && vld[19:10] !== 10'h000) fcnt++;
      else grp(vld[19:10], {rise[159:80], fall[159:80]}, bq);
      if (ack === 1'b1 && !we && rq.size() != 0) begin
         e = rq.pop_front();
         cmp(160'(rdat & e[63:32]), 160'(e[31:0] & e[63:32]));
      end
   end
   // Classic single cycle; read expectation noted before the request
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w) rq.push_back({m, d});
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) cmp(160'h1, 160'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // Random read bursts; waits a bounded time for every pair to surface
   task automatic burst(input int n, input logic [19:0] en, input logic pu);
      logic [159:0] a;
      logic [159:0] b;
      repeat (n) begin
         @(negedge ref_top);
         for (int i = 0; i < 5; i++) begin
            a[i*32 +: 32] = $urandom;
            b[i*32 +: 32] = $urandom;
         end
         beat_a <= a;
         beat_b <= b;
         dqs_en <= en;
         send <= 1'b1;
         if (pu && en[9:0] != 10'h000) tq.push_back({a[79:0], b[79:0]});
         if (pu && en[19:10] != 10'h000) bq.push_back({a[159:80], b[159:80]});
      end
      @(negedge ref_top);
      send <= 1'b0;
      for (int k = 0; k < 80 && tq.size() + bq.size() != 0; k++) @(posedge clk_i);
      cmp(160'(tq.size() + bq.size()), 160'h0);
   endtask : burst
   // First half during reference high, second during low
   task automatic out_chk(input logic [7:0] a, input logic [7:0] b);
      @(posedge ref_top);
      repeat (6) @(posedge clk_i);
      cmp(160'(dq_out), 160'(a));
      @(negedge ref_top);
      repeat (6) @(posedge clk_i);
      cmp(160'(dq_out), 160'(b));
   endtask : out_chk
   task automatic give_verdict;
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] x;
      int          rel;
      void'($urandom(2163));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rel = cyc_n;
      burst(2, 20'hF_FFFF, 1'b0);
      for (int i = 0; i < 4; i++) wb(1'b0, (i == 3) ? 8'h10 : 8'(i * 4), RV[i], '1, r);
      do wb(1'b0, `DDRPS_ADR_STAT, 32'h0000_0000, 32'hFFE0_E0FC, r);
      while (r[1:0] != 2'b11 && cyc_n - rel < 5000);
      cmp(160'({r[1:0], cyc_n - rel <= 4096}), 160'h7);
      wb(1'b0, `DDRPS_ADR_STAT, 32'h0003_0403, 32'h001F_1F03, r);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `DDRPS_ADR_CTRL, {27'h000_0000, MD[i], MD[i], 1'b1}, '0, r);
         burst(3, {MSK[i], MSK[i]}, 1'b1);
      end
      wb(1'b1, `DDRPS_ADR_PHASE, 32'h002D_0078, '0, r);
      repeat (3) @(posedge ref_top);
      wb(1'b0, `DDRPS_ADR_STAT, 32'h0002_0500, 32'h001F_1F00, r);
      burst(3, 20'hF_FFFF, 1'b1);
      // Bottom moves to a bank without strobe delay; top stays capable
      free_bot <= 1'b1;
      wb(1'b1, `DDRPS_ADR_BANK, 32'h0000_0504, '0, r);
      burst(4, 20'h0_03FF, 1'b1);
      cmp(160'(fcnt >= 2), 160'h1);
      wb(1'b1, `DDRPS_ADR_BANK, 32'h0000_0803, '0, r);
      repeat (4) @(posedge ref_top);
      free_bot <= 1'b0;
      burst(2, 20'hF_FFFF, 1'b1);
      // Output registers load with enable high and hold with it low
      wb(1'b1, `DDRPS_ADR_CTRL, 32'h0000_0001, '0, r);
      x = 16'($urandom);
      dout_a <= x[7:0];
      dout_b <= x[15:8];
      out_chk(x[7:0], x[15:8]);
      wb(1'b1, `DDRPS_ADR_CTRL, 32'h0000_0000, '0, r);
      dout_a <= ~x[7:0];
      dout_b <= ~x[15:8];
      out_chk(x[7:0], x[15:8]);
      wb(1'b1, `DDRPS_ADR_CTRL, 32'h0000_0001, '0, r);
      out_chk(~x[7:0], ~x[15:8]);
      // Enable request in the high phase waits for the falling edge
      @(posedge ref_top);
      @(posedge clk_i);
      oe <= 1'b1;
      repeat (5) @(posedge clk_i);
      cmp(160'(dq_oe), 160'h0);
      @(negedge ref_top);
      repeat (7) @(posedge clk_i);
      cmp(160'(dq_oe), 160'h1);
      give_verdict();
   end
endmodule : ddrps_capture_bench

/* File: ddrps_ddr_model.sv */
// Memory-side model: read strobes and data edge-aligned to the reference clock
module ddrps_ddr_model (
   input  wire logic         ref_clk_i,
   input  wire logic         send_i,
   input  wire logic [19:0]  dqs_en_i,
   input  wire logic [159:0] beat_a_i,
   input  wire logic [159:0] beat_b_i,
   output logic      [19:0]  dqs_o,
   output logic      [159:0] dq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic live_ff;
   ////////////////////////////////////////////////////////////
   initial begin
      dqs_o = 20'h0_0000;
      dq_o = '0;
      live_ff = 1'b0;
   end
   // Strobe follows the reference, so both run at one rate
   // Idle bus shows the inverse of the last value, never a stale copy
   always @(ref_clk_i) begin
      if (ref_clk_i) begin
         live_ff <= send_i;
         dqs_o <= send_i ? dqs_en_i : 20'h0_0000;
         dq_o <= send_i ? beat_a_i : ~dq_o;
      end else begin
         dqs_o <= 20'h0_0000;
         dq_o <= live_ff ? beat_b_i : ~dq_o;
      end
   end
endmodule : ddrps_ddr_model

/* File: ddrps_params.svh */
// Register offsets, field positions, reset values and counts of the strobe capture block
`ifndef DDRPS_PARAMS_SVH
`define DDRPS_PARAMS_SVH

`define DDRPS_ADR_CTRL      8'h00
`define DDRPS_ADR_PHASE     8'h04
`define DDRPS_ADR_BANK      8'h08
`define DDRPS_ADR_STAT      8'h0C

`define DDRPS_CTRL_CE_BIT   0
`define DDRPS_CTRL_TMODE    2:1
`define DDRPS_CTRL_BMODE    4:3
`define DDRPS_PHASE_TOP     8:0
`define DDRPS_PHASE_BOT     24:16
`define DDRPS_BANK_TOP      3:0
`define DDRPS_BANK_BOT      11:8

`define DDRPS_CTRL_RST      32'h0000_0001
`define DDRPS_PHASE_RST     32'h0048_005A
`define DDRPS_BANK_RST      32'h0000_0703

`define DDRPS_LANES         20
`define DDRPS_SIDE_LANES    10
`define DDRPS_DQ_W          8
`define DDRPS_TAPS          32
`define DDRPS_TAP_W         5
`define DDRPS_PER_W         8
`define DDRPS_DEG_W         9
`define DDRPS_DEG_FULL      17'h0_0168
`define DDRPS_TAP_MAX       17'h0_001F
`define DDRPS_LOCK_EDGES    9'h004
`define DDRPS_SETTLE_CYC    9'h100

`endif

/* File: ddrps_phase_ref.sv */
// Phase reference circuit: measures one side's reference clock and sets its delay taps
`include "ddrps_params.svh"
module ddrps_phase_ref (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ref_clk_i,
   input  wire logic [`DDRPS_DEG_W-1:0]  phase_deg_i,
   output logic      [`DDRPS_TAP_W-1:0]  taps_o,
   output logic                          settled_o,
   output logic                          ref_lvl_o,
   output logic                          ref_rise_o,
   output logic                          ref_fall_o
);
   logic                     sync1_ff, sync2_ff, sync3_ff;
   logic [`DDRPS_PER_W-1:0]  per_ff;
   logic [`DDRPS_TAP_W-1:0]  taps_ff;
   logic [2:0]               edges_ff;
   logic [8:0]               seen_ff;
   ddrps_pkg::ddrps_state_t  st_ff, nxt_st;
   logic [16:0]              prod, quot;
   logic [`DDRPS_TAP_W-1:0]  nxt_taps;

   // Reference clock is foreign: two flops, then the edge tap
   always_ff @(posedge clk_i) begin
      sync1_ff <= ref_clk_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
   end
   assign ref_lvl_o  = sync2_ff;
   assign ref_rise_o = sync2_ff & ~sync3_ff;
   assign ref_fall_o = ~sync2_ff & sync3_ff;

   // Taps = period * degrees / 360, clamped to the line length
   assign prod     = 17'(per_ff) * 17'(phase_deg_i);
   assign quot     = prod / `DDRPS_DEG_FULL;
   assign nxt_taps = (quot > `DDRPS_TAP_MAX) ? `DDRPS_TAP_W'(`DDRPS_TAP_MAX)
                                             : quot[`DDRPS_TAP_W-1:0];

   // Period counter saturates so a stopped clock cannot wrap
   always_ff @(posedge clk_i) begin
      if (rst_i || ref_rise_o) begin
         per_ff <= `DDRPS_PER_W'(1);
      end else if (per_ff != '1) begin
         per_ff <= per_ff + `DDRPS_PER_W'(1);
      end
   end

   // Search state: lock after a few whole periods
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         ddrps_pkg::DDRPS_ST_IDLE: if (ref_rise_o) nxt_st = ddrps_pkg::DDRPS_ST_MEAS;
         ddrps_pkg::DDRPS_ST_MEAS: if (ref_rise_o && 9'(edges_ff) >= `DDRPS_LOCK_EDGES)
                                      nxt_st = ddrps_pkg::DDRPS_ST_LOCK;
         ddrps_pkg::DDRPS_ST_LOCK: nxt_st = st_ff;
         default:                  nxt_st = ddrps_pkg::DDRPS_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff    <= ddrps_pkg::DDRPS_ST_IDLE;
         edges_ff <= 3'h0;
         taps_ff  <= '0;
      end else begin
         st_ff <= nxt_st;
         if (ref_rise_o && edges_ff != 3'h7) edges_ff <= edges_ff + 3'h1;
         // New setting lands on every reference rising edge once out of idle, for every lane of the side
         if (ref_rise_o && st_ff != ddrps_pkg::DDRPS_ST_IDLE) taps_ff <= nxt_taps;
      end
   end
   assign taps_o    = taps_ff;
   assign settled_o = (st_ff == ddrps_pkg::DDRPS_ST_LOCK);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   always_ff @(posedge clk_i) begin
      if (rst_i) seen_ff <= 9'h000;
      else if (ref_rise_o && seen_ff != 9'h1FF) seen_ff <= seen_ff + 9'h001;
   end

   a_settle_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      seen_ff >= `DDRPS_SETTLE_CYC |-> settled_o)
      else $error("phase reference not settled within 256 reference cycles");
   a_taps_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      !ref_rise_o |=> $stable(taps_o))
      else $error("delay taps changed away from a reference edge");
   c_locked: cover property (@(posedge clk_i) disable iff (rst_i) $rose(settled_o));
endmodule : ddrps_phase_ref

/* File: ddrps_pkg.sv */
// Types shared by the strobe capture block
package ddrps_pkg;
   // Gray-coded along the bus-width order
   typedef enum logic [1:0] {
      DDRPS_X8  = 2'b00,
      DDRPS_X16 = 2'b01,
      DDRPS_X32 = 2'b11
   } ddrps_mode_t;

   // Gray-coded along idle, measure, locked
   typedef enum logic [1:0] {
      DDRPS_ST_IDLE = 2'b00,
      DDRPS_ST_MEAS = 2'b01,
      DDRPS_ST_LOCK = 2'b11
   } ddrps_state_t;
endpackage : ddrps_pkg
